// ### core/pts_pkg.sv
// Purpose: shared types of the period timer
// Assumes: constants live in pts_regs.svh
// Notes: types only
package pts_pkg;
	// control register layout, top bit unimplemented
	typedef struct packed {
		logic [3:0] postSel;
		logic timerOn;
		logic [1:0] preSel;
	} pts_ctrl_s;
	// one apb request as seen by the slave
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} pts_apb_s;
endpackage : pts_pkg

// ### core/pts_regs.svh
// Purpose: offsets, fields, reset values and counts of the period timer
// Assumes: 32-bit APB, one register per aligned word
// Notes: definitions only
`ifndef PTS_REGS_SVH
`define PTS_REGS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PTS_OFS_COUNT 8'h00
`define PTS_OFS_PERIOD 8'h04
`define PTS_OFS_CTRL 8'h08
`define PTS_OFS_STATUS 8'h0C
`define PTS_OFS_CLEAR 8'h10
`define PTS_OFS_ENABLE 8'h14
`define PTS_OFS_GLOBAL 8'h18
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PTS_RST_COUNT 8'h00
`define PTS_RST_PERIOD 8'hFF
`define PTS_RST_CTRL 7'h00
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PTS_FLAG_MATCH 0
`define PTS_GLB_PERIPH 0
`define PTS_GLB_GLOBAL 1
// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define PTS_INSTR_DIV 4
`define PTS_PRE_LIM1 4'h0
`define PTS_PRE_LIM4 4'h3
`define PTS_PRE_LIM16 4'hF
`endif

// ### core/pts_timer.sv
// Purpose: 8-bit period timer with prescaler, postscaler and apb slave
// Assumes: clk is the system oscillator, 100 MHz; rst_n is any reset
// Notes: zero-wait apb; registered outputs only
//
// Overview of operation
// - timer clocked by oscillator divided by four
// - prescaler divides by 1, 4 or 16
// - counter counts up from zero until match
// - on match counter reloads zero next increment
// - every match advances the postscaler
// - postscale code N gives ratio 1:(N+1)
// - postscaler output sets the match flag
// - counter and period readable, writable, reset values
// - timer counts only while on bit set
// - counter write clears prescaler and postscaler
// - control write clears prescaler and postscaler
// - any reset clears prescaler and postscaler
// - control write leaves counter unchanged
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "pts_regs.svh"

module pts_timer #(
	parameter int INSTR_DIV = `PTS_INSTR_DIV
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// events
	output logic irq,
	output logic matchPulse
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// divider must be a power of two that fits the phase counter
	if (INSTR_DIV < 2 || INSTR_DIV > 16 ||
		(INSTR_DIV & (INSTR_DIV - 1)) != 0) begin : g_bad_div
		$error("INSTR_DIV must be a power of two from 2 to 16");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	localparam logic [3:0] PHASE_LAST = 4'(INSTR_DIV - 1);
	logic [3:0] phase_r; // instruction clock phase
	logic [3:0] pres_r; // prescaler count
	logic [3:0] post_r; // postscaler count
	logic [7:0] count_r; // timer count
	logic [7:0] period_r; // period value
	pts_pkg::pts_ctrl_s ctrl_r; // timer control
	logic [7:0] flags_r; // sticky event flags
	logic [7:0] irqEn_r; // per-flag enables
	logic [1:0] glb_r; // peripheral and global enables
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic irq_r;
	logic match_r;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	pts_pkg::pts_apb_s req;
	assign req = '{sel: psel, enable: penable, write: pwrite,
		addr: paddr, wdata: pwdata};
	// setup cycle and committing access edge
	wire setupCyc = req.sel && !req.enable;
	wire accessEdge = req.sel && req.enable && pready_r;
	wire wrEdge = accessEdge && req.write;
	// address hits
	wire hitCount = req.addr == `PTS_OFS_COUNT;
	wire hitPeriod = req.addr == `PTS_OFS_PERIOD;
	wire hitCtrl = req.addr == `PTS_OFS_CTRL;
	wire hitStatus = req.addr == `PTS_OFS_STATUS;
	wire hitClear = req.addr == `PTS_OFS_CLEAR;
	wire hitEnable = req.addr == `PTS_OFS_ENABLE;
	wire hitGlobal = req.addr == `PTS_OFS_GLOBAL;
	wire hitAny = hitCount | hitPeriod | hitCtrl | hitStatus |
		hitClear | hitEnable | hitGlobal;
	// write strobes per register
	wire wrCount = wrEdge && hitCount;
	wire wrPeriod = wrEdge && hitPeriod;
	wire wrCtrl = wrEdge && hitCtrl;
	wire wrClear = wrEdge && hitClear;
	wire wrEnable = wrEdge && hitEnable;
	wire wrGlobal = wrEdge && hitGlobal;
	// read data mux, unused bits zero
	wire [7:0] ctrlRd = {1'b0, ctrl_r};
	wire [31:0] rdMux =
		hitCount ? {24'h000000, count_r} :
		hitPeriod ? {24'h000000, period_r} :
		hitCtrl ? {24'h000000, ctrlRd} :
		hitStatus ? {24'h000000, flags_r} :
		hitEnable ? {24'h000000, irqEn_r} :
		hitGlobal ? {30'h0000000, glb_r} :
		32'h00000000;

	// ----------------------------------------------------------------
	// timer datapath
	// ----------------------------------------------------------------
	// instruction tick
	wire instrTick = phase_r == PHASE_LAST;
	wire [3:0] preLim =
		ctrl_r.preSel[1] ? `PTS_PRE_LIM16 :
		ctrl_r.preSel[0] ? `PTS_PRE_LIM4 : `PTS_PRE_LIM1;
	wire scalerClr = wrCount || wrCtrl;
	wire preStep = instrTick && ctrl_r.timerOn;
	// a clear also drops a coincident output pulse
	// so a control write can never move the counter
	wire incPulse = preStep && pres_r == preLim && !scalerClr;
	wire isMatch = count_r == period_r;
	wire matchEvt = incPulse && isMatch;
	wire postOut = matchEvt && post_r == ctrl_r.postSel;
	// sticky flags: set wins over clear
	wire [7:0] flagSet = {7'h00, postOut};
	wire [7:0] flagClr = wrClear ? req.wdata[7:0] : 8'h00;
	wire [7:0] flagsNxt = (flags_r & ~flagClr) | flagSet;
	wire [7:0] irqEnNxt = wrEnable ? req.wdata[7:0] : irqEn_r;
	wire [1:0] glbNxt = wrGlobal ? req.wdata[1:0] : glb_r;
	wire irqNxt = (|(flagsNxt & irqEnNxt)) &&
		glbNxt[`PTS_GLB_PERIPH] && glbNxt[`PTS_GLB_GLOBAL];

	// ----------------------------------------------------------------
	// instruction clock divider
	// ----------------------------------------------------------------
	// free-running divide of oscillator
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= 4'h0;
		end else if (instrTick) begin
			phase_r <= 4'h0;
		end else begin
			phase_r <= phase_r + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------
	// write and reset clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pres_r <= 4'h0;
		end else if (scalerClr || incPulse) begin
			pres_r <= 4'h0;
		end else if (preStep) begin
			pres_r <= pres_r + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// postscaler
	// ----------------------------------------------------------------
	// advance on each match
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			post_r <= 4'h0;
		end else if (scalerClr || postOut) begin
			post_r <= 4'h0;
		end else if (matchEvt) begin
			post_r <= post_r + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// counter and period
	// ----------------------------------------------------------------
	// wrap to zero on match
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= `PTS_RST_COUNT;
		end else if (wrCount) begin
			count_r <= req.wdata[7:0];
		end else if (matchEvt) begin
			count_r <= 8'h00;
		end else if (incPulse) begin
			count_r <= count_r + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			period_r <= `PTS_RST_PERIOD;
		end else if (wrPeriod) begin
			period_r <= req.wdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	// seven bits held, top bit absent
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= `PTS_RST_CTRL;
		end else if (wrCtrl) begin
			ctrl_r <= req.wdata[6:0];
		end
	end

	// ----------------------------------------------------------------
	// interrupt registers
	// ----------------------------------------------------------------
	// flags, enables, output
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_r <= 8'h00;
			irqEn_r <= 8'h00;
			glb_r <= 2'h0;
			irq_r <= 1'b0;
			match_r <= 1'b0;
		end else begin
			flags_r <= flagsNxt;
			irqEn_r <= irqEnNxt;
			glb_r <= glbNxt;
			irq_r <= irqNxt;
			match_r <= matchEvt;
		end
	end

	// ----------------------------------------------------------------
	// apb answer
	// ----------------------------------------------------------------
	// answer raised in setup, dropped after access
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else if (setupCyc) begin
			pready_r <= 1'b1;
			pslverr_r <= !hitAny;
			prdata_r <= req.write ? 32'h00000000 : rdMux;
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end
	end

	// output drive
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;
	assign matchPulse = match_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	// increments only on instruction ticks
	property p_tickOnly;
		@(posedge clk) disable iff (!rst_n)
		incPulse |-> phase_r == PHASE_LAST;
	endproperty
	a_tickOnly: assert property (p_tickOnly)
		else $error("increment off instruction tick");

	// divide by one follows every tick
	property p_preOne;
		@(posedge clk) disable iff (!rst_n)
		(ctrl_r.preSel == 2'b00 && ctrl_r.timerOn && instrTick &&
			!scalerClr) |-> incPulse;
	endproperty
	a_preOne: assert property (p_preOne)
		else $error("prescale 1 missed a tick");

	property p_countUp;
		@(posedge clk) disable iff (!rst_n)
		(incPulse && !isMatch && !wrCount)
			|=> count_r == $past(count_r) + 8'h01;
	endproperty
	a_countUp: assert property (p_countUp)
		else $error("counter did not increment");

	property p_wrap;
		@(posedge clk) disable iff (!rst_n)
		(incPulse && isMatch && !wrCount) |=> count_r == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("counter did not wrap at match");

	// postscaler wraps after the selected count
	property p_postRatio;
		@(posedge clk) disable iff (!rst_n)
		(matchEvt && !scalerClr) |=> post_r ==
			(($past(post_r) == $past(ctrl_r.postSel)) ? 4'h0 :
			$past(post_r) + 4'h1);
	endproperty
	a_postRatio: assert property (p_postRatio)
		else $error("postscaler fired at wrong count");

	// postscaler moves only on a match or on a counter or control write clear
	property p_postHold;
		@(posedge clk) disable iff (!rst_n)
		(!matchEvt && !scalerClr) |=> $stable(post_r);
	endproperty
	a_postHold: assert property (p_postHold)
		else $error("postscaler moved without a match");

	property p_flagSet;
		@(posedge clk) disable iff (!rst_n)
		postOut |=> flags_r[`PTS_FLAG_MATCH];
	endproperty
	a_flagSet: assert property (p_flagSet)
		else $error("match flag not set");

	property p_off;
		@(posedge clk) disable iff (!rst_n)
		(!ctrl_r.timerOn && !wrCount) |=> $stable(count_r);
	endproperty
	a_off: assert property (p_off)
		else $error("counter moved while off");

	property p_cntClr;
		@(posedge clk) disable iff (!rst_n)
		wrCount |=> pres_r == 4'h0 && post_r == 4'h0;
	endproperty
	a_cntClr: assert property (p_cntClr)
		else $error("scalers kept after counter write");

	property p_ctlClr;
		@(posedge clk) disable iff (!rst_n)
		wrCtrl |=> pres_r == 4'h0 && post_r == 4'h0;
	endproperty
	a_ctlClr: assert property (p_ctlClr)
		else $error("scalers kept after control write");

	property p_ctlKeep;
		@(posedge clk) disable iff (!rst_n)
		wrCtrl |=> count_r == $past(count_r);
	endproperty
	a_ctlKeep: assert property (p_ctlKeep)
		else $error("control write changed counter");

	property p_rstVal;
		@(posedge clk)
		$rose(rst_n) |-> count_r == 8'h00 && period_r == 8'hFF &&
			pres_r == 4'h0 && post_r == 4'h0;
	endproperty
	a_rstVal: assert property (p_rstVal)
		else $error("wrong values after reset");

	property p_irq;
		@(posedge clk) disable iff (!rst_n)
		irq == ((|(flags_r & irqEn_r)) && glb_r[0] && glb_r[1]);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt level mismatch");

endmodule : pts_timer

// ### tb/tb_top.sv
// Purpose: self-checking bench for the period timer over apb
// Assumes: zero-wait slave, instruction tick every INSTR_DIV clocks
// Notes: every scenario is one task that drives and judges
`timescale 1ns/1ns
`include "pts_regs.svh"

module tb_top;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic matchPulse;
	int errors = 0; // mismatches seen
	int check_count = 0; // comparisons made
	int cyc = 0; // free cycle count, also the timeout
	logic [31:0] rdq; // last read data
	logic rde; // last error response

	// design under test, default divide by four
	pts_timer #(.INSTR_DIV(4)) pts_timer_inst (.clk(clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .matchPulse(matchPulse));

	// 100 MHz clock
	always #5 clk = ~clk;

	// cycle counter and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			errors++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// verdict and end of run
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	// compare one value
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one apb transfer, entered and left just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// hold the access phase until ready is sampled at an edge
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdq = prdata;
		rde = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// write and read with a check of the answer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h000000, d});
		chk("write error", 32'h0, {31'h0, rde});
	endtask : wr

	task automatic rd(input string what, input logic [7:0] a,
		input logic [7:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, {24'h000000, exp}, rdq);
	endtask : rd

	// wait for the next match pulse, return its cycle
	task automatic wait_pulse(output int t);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (matchPulse !== 1'b1 && n < 3000);
		t = cyc;
		chk("pulse seen", 32'h1, {31'h0, matchPulse});
	endtask : wait_pulse

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// reset values, read back, unimplemented bit, unmapped place
	task automatic sc_regs();
		rd("count rst", `PTS_OFS_COUNT, 8'h00);
		rd("period rst", `PTS_OFS_PERIOD, 8'hFF);
		rd("ctrl rst", `PTS_OFS_CTRL, 8'h00);
		rd("status rst", `PTS_OFS_STATUS, 8'h00);
		wr(`PTS_OFS_CTRL, 8'hFB);
		rd("ctrl top bit", `PTS_OFS_CTRL, 8'h7B);
		wr(`PTS_OFS_PERIOD, 8'hA5);
		rd("period rw", `PTS_OFS_PERIOD, 8'hA5);
		wr(`PTS_OFS_COUNT, 8'h5A);
		rd("count rw", `PTS_OFS_COUNT, 8'h5A);
		wr(`PTS_OFS_CTRL, 8'h7B);
		rd("count kept", `PTS_OFS_COUNT, 8'h5A);
		repeat (100) @(posedge clk);
		rd("count off", `PTS_OFS_COUNT, 8'h5A);
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, rde});
		chk("unmapped data", 32'h0, rdq);
	endtask : sc_regs

	// match spacing for every prescale code, period 3
	task automatic sc_prescale();
		int t0;
		int t1;
		int dv;
		for (int c = 0; c < 4; c++) begin
			dv = (c == 0) ? 1 : ((c == 1) ? 4 : 16);
			wr(`PTS_OFS_PERIOD, 8'h03);
			wr(`PTS_OFS_COUNT, 8'h00);
			wr(`PTS_OFS_CTRL, 8'h04 | c[7:0]);
			wait_pulse(t0);
			wait_pulse(t1);
			chk("match spacing", 4 * 4 * dv, t1 - t0);
		end
	endtask : sc_prescale

	// counter and control writes restart the prescaler
	task automatic sc_restart();
		int t0;
		int t1;
		logic [7:0] a;
		wr(`PTS_OFS_PERIOD, 8'h00);
		wr(`PTS_OFS_CTRL, 8'h06);
		for (int i = 0; i < 2; i++) begin
			a = (i == 0) ? `PTS_OFS_COUNT : `PTS_OFS_CTRL;
			repeat (37) @(posedge clk);
			wr(a, (i == 0) ? 8'h00 : 8'h06);
			t0 = cyc;
			wait_pulse(t1);
			chk("restart", 32'h1, {31'h0, (t1 - t0 >= 58 && t1 - t0 <= 70)});
		end
	endtask : sc_restart

	// postscale ratio, sticky flag, masking and clearing
	task automatic sc_post(input logic [3:0] code);
		int n;
		int k;
		wr(`PTS_OFS_CTRL, 8'h00);
		wr(`PTS_OFS_PERIOD, 8'h03);
		wr(`PTS_OFS_COUNT, 8'h00);
		wr(`PTS_OFS_CLEAR, 8'h01);
		wr(`PTS_OFS_ENABLE, 8'h01);
		wr(`PTS_OFS_GLOBAL, 8'h03);
		wr(`PTS_OFS_CTRL, {1'b0, code, 3'b100});
		n = 0;
		k = 0;
		while (k < 800) begin
			@(posedge clk);
			if (matchPulse === 1'b1) n++;
			if (irq === 1'b1) break;
			k++;
		end
		@(posedge clk);
		chk("post ratio", code + 1, n);
		wr(`PTS_OFS_CTRL, 8'h00);
		rd("flag sticky", `PTS_OFS_STATUS, 8'h01);
		chk("irq on", 32'h1, {31'h0, irq});
		rd("enable rb", `PTS_OFS_ENABLE, 8'h01);
		rd("global rb", `PTS_OFS_GLOBAL, 8'h03);
		wr(`PTS_OFS_GLOBAL, 8'h01);
		chk("irq no global", 32'h0, {31'h0, irq});
		wr(`PTS_OFS_GLOBAL, 8'h03);
		wr(`PTS_OFS_ENABLE, 8'h00);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(`PTS_OFS_ENABLE, 8'h01);
		wr(`PTS_OFS_CLEAR, 8'h01);
		rd("flag clear", `PTS_OFS_STATUS, 8'h00);
		chk("irq clear", 32'h0, {31'h0, irq});
	endtask : sc_post

	// reset in mid-run restores the register values
	task automatic sc_rerun();
		wr(`PTS_OFS_PERIOD, 8'h10);
		wr(`PTS_OFS_CTRL, 8'h04);
		repeat (20) @(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd("count rerun", `PTS_OFS_COUNT, 8'h00);
		rd("period rerun", `PTS_OFS_PERIOD, 8'hFF);
		rd("ctrl rerun", `PTS_OFS_CTRL, 8'h00);
	endtask : sc_rerun

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		sc_regs();
		sc_prescale();
		sc_restart();
		sc_post(4'h0);
		sc_post(4'h2);
		sc_post(4'hF);
		sc_rerun();
		final_report();
	end
endmodule : tb_top
